// *** core/frc_pkg.sv ***
// What this block does
// - erase error flag is one on erase or blank check failure, else zero.
// - suspend flag is one only once erase suspend is acknowledged.
// - ready flag reads zero during any busy operation, stop or activation; otherwise one.
// - control zero resets to zero; enable, mode, stop, seq reset, three irq enables.
// - flash stop acts only with rewrite enabled; software sets it while ready.
// - while flash stop is one, flash access is blocked and circuits held initialized.
// - writing one to sequence reset aborts the command; the bit reads zero.
// - sequence reset acts only when rewrite enabled and busy.
// - after forced stop latency the command ends and reads are allowed.
// - sequence reset during suspend also clears the suspended state.
// - program area stays readable while a data area sequence is reset.
// - error irq enable raises interrupt on program, erase, sequence or blank errors.
// - access error irq enable raises interrupt on access to block being rewritten.
// - ready irq enable raises interrupt on each busy to ready change.
// - control one resets zero; bits 0-2 read zero; lock disable; four block inhibits.
// - clearing rewrite enable clears all four block inhibit bits.
// - lock disable bypasses locks; erase with it set unlocks the lock bit.
// - lock disable auto-clears on completion, seq error, suspend, disable, stop, seq reset.
// - ready request flag set on busy to ready with enable; software only clears.
// - access error request set on busy access or errors while the enables allow.
package frc_pkg;
    localparam logic [8:0] FRC_STATUS_ADDR = 9'h1b2;
    localparam logic [8:0] FRC_CTRL0_ADDR  = 9'h1b4;
    localparam logic [8:0] FRC_CTRL1_ADDR  = 9'h1b5;
    localparam logic [7:0] FRC_CTRL0_RST   = 8'h00;
    localparam logic [7:0] FRC_CTRL1_RST   = 8'h00;
    localparam int FRC_C0_EN     = 1;
    localparam int FRC_C0_MODE1  = 2;
    localparam int FRC_C0_STOP   = 3;
    localparam int FRC_C0_SEQRST = 4;
    localparam int FRC_C0_ERRIE  = 5;
    localparam int FRC_C0_AEIE   = 6;
    localparam int FRC_C0_RDYIE  = 7;
    localparam int FRC_C1_LOCKDIS = 3;
    localparam int FRC_C1_INH_LO  = 4;
    localparam int FRC_ST_RDYREQ  = 0;
    localparam int FRC_ST_AEREQ   = 1;
    localparam int FRC_ST_PRGERR  = 4;
    localparam int FRC_ST_ERSERR  = 5;
    localparam int FRC_ST_SUSP    = 6;
    localparam int FRC_ST_READY   = 7;
    localparam int FRC_CLK_MHZ       = 100;
    localparam int FRC_STOP_LAT_NS   = 1000;
    localparam int FRC_STOP_LAT_CYC  = (FRC_STOP_LAT_NS * FRC_CLK_MHZ + 999) / 1000;
    localparam logic [7:0] FRC_STOP_LAT_CNT = 8'(FRC_STOP_LAT_CYC);
    // events from the command engine
    typedef struct packed {
        logic busy;
        logic suspended;
        logic prog_done;
        logic erase_done;
        logic prog_err;
        logic erase_err;
        logic blank_err;
        logic seq_err;
        logic busy_access;
    } frc_engine_t;
    // control to the flash unit
    typedef struct packed {
        logic       rewrite_enable;
        logic       mode1_select;
        logic       block_access;
        logic       abort_cmd;
        logic       clear_suspend;
        logic       lock_disable;
        logic [3:0] block_inhibit;
    } frc_ctrl_t;
endpackage : frc_pkg

// *** core/frc_ctrl.sv ***
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ns
module frc_ctrl (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // avalon-mm slave
    input  wire logic [8:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [7:0]       avs_writedata,
    output logic      [7:0]       avs_readdata,
    output logic                  avs_waitrequest,
    // flash unit
    input  wire frc_pkg::frc_engine_t eng,
    output frc_pkg::frc_ctrl_t    ctl,
    // interrupt requests
    output logic                  irq_error,
    output logic                  irq_access,
    output logic                  irq_ready
);
    import frc_pkg::*;

    // ************
    // registers
    // ************
    logic [7:0] c0_reg, c1_reg;
    logic       rdyreq_reg, aereq_reg, busy_d_reg, ack_reg;
    logic       abort_reg, stopping_reg, clrsusp_reg;
    logic [7:0] lat_reg;
    logic       susp_d_reg;
    logic       wr_hit, rd_hit, busy_eff, seq_go, c0_wr, c1_wr, err_any;

    // ************
    // bus decode
    // ************
    // accept on second cycle: one waitstate keeps the timing simple
    assign wr_hit = avs_write && !ack_reg;
    assign rd_hit = avs_read && !ack_reg;
    assign c0_wr  = wr_hit && avs_address == FRC_CTRL0_ADDR;
    assign c1_wr  = wr_hit && avs_address == FRC_CTRL1_ADDR;
    assign busy_eff = eng.busy || abort_reg || stopping_reg;
    assign seq_go = c0_wr && avs_writedata[FRC_C0_SEQRST] && c0_reg[FRC_C0_EN] && busy_eff;
    assign err_any = eng.prog_err || eng.erase_err || eng.blank_err || eng.seq_err;

    // ************
    // bus handshake
    // ************
    // handshake
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_reg         <= 1'b0;
            avs_waitrequest <= 1'b1;
        end else begin
            ack_reg         <= (avs_read || avs_write) && !ack_reg;
            avs_waitrequest <= !((avs_read || avs_write) && !ack_reg);
        end
    end

    // ************
    // read path
    // ************
    // read data, unmapped reads zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            avs_readdata <= 8'h00;
        end else if (rd_hit) begin
            if (avs_address == FRC_STATUS_ADDR) begin
                avs_readdata <= {!busy_eff, eng.suspended, eng.erase_err || eng.blank_err,
                                 eng.prog_err, 2'b00, aereq_reg, rdyreq_reg};
            end else if (avs_address == FRC_CTRL0_ADDR) begin
                avs_readdata <= c0_reg & ~(8'h01 << FRC_C0_SEQRST);
            end else if (avs_address == FRC_CTRL1_ADDR) begin
                avs_readdata <= {c1_reg[7:3], 3'b000};
            end else begin
                avs_readdata <= 8'h00;
            end
        end
    end

    // ************
    // control registers
    // ************
    // control zero; stop only with rewrite enabled
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            c0_reg <= FRC_CTRL0_RST;
        end else if (c0_wr) begin
            c0_reg <= {avs_writedata[7:5], 1'b0,
                       avs_writedata[FRC_C0_STOP] && avs_writedata[FRC_C0_EN],
                       avs_writedata[2:1], 1'b0};
        end
    end

    // control one: lock disable and block inhibits
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            c1_reg <= FRC_CTRL1_RST;
        end else begin
            if (c1_wr) begin
                c1_reg <= {avs_writedata[7:3], 3'b000};
            end
            if (eng.prog_done || eng.erase_done || eng.seq_err || (eng.suspended && !susp_d_reg)
                || !c0_reg[FRC_C0_EN] || c0_reg[FRC_C0_STOP] || seq_go) begin
                c1_reg[FRC_C1_LOCKDIS] <= 1'b0;
            end
            if (!c0_reg[FRC_C0_EN]) begin
                c1_reg[7:4] <= 4'h0;
            end
        end
    end

    // suspend entry edge; reset low matches the idle level, so no false edge after reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            susp_d_reg <= 1'b0;
        end else begin
            susp_d_reg <= eng.suspended;
        end
    end

    // ************
    // sequence reset
    // ************
    // forced stop latency after sequence reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            abort_reg   <= 1'b0;
            clrsusp_reg <= 1'b0;
            lat_reg     <= 8'h00;
        end else if (seq_go) begin
            abort_reg   <= 1'b1;
            clrsusp_reg <= eng.suspended;
            lat_reg     <= FRC_STOP_LAT_CNT;
        end else if (abort_reg) begin
            if (lat_reg <= 8'h01) begin
                abort_reg   <= 1'b0;
                clrsusp_reg <= 1'b0;
            end
            lat_reg <= lat_reg - 8'h01;
        end
    end

    // ************
    // flash stop and start
    // ************
    // one busy cycle while stopping or restarting the flash
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stopping_reg <= 1'b0;
        end else begin
            stopping_reg <= c0_wr && (avs_writedata[FRC_C0_STOP] != c0_reg[FRC_C0_STOP]);
        end
    end

    // ************
    // interrupt requests
    // ************
    // request flags, the set wins over a software clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_d_reg <= 1'b0;
            rdyreq_reg <= 1'b0;
            aereq_reg  <= 1'b0;
        end else begin
            busy_d_reg <= busy_eff;
            if (busy_d_reg && !busy_eff && c0_reg[FRC_C0_RDYIE]) begin
                rdyreq_reg <= 1'b1;
            end else if (wr_hit && avs_address == FRC_STATUS_ADDR && !avs_writedata[FRC_ST_RDYREQ]) begin
                rdyreq_reg <= 1'b0;
            end
            if ((eng.busy_access && c0_reg[FRC_C0_AEIE]) || (err_any && c0_reg[FRC_C0_ERRIE])) begin
                aereq_reg <= 1'b1;
            end else if (wr_hit && avs_address == FRC_STATUS_ADDR && !avs_writedata[FRC_ST_AEREQ]) begin
                aereq_reg <= 1'b0;
            end
        end
    end

    // ************
    // outputs
    // ************
    // outputs toward flash unit and interrupt lines
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl        <= '0;
            irq_error  <= 1'b0;
            irq_access <= 1'b0;
            irq_ready  <= 1'b0;
        end else begin
            ctl.rewrite_enable <= c0_reg[FRC_C0_EN];
            ctl.mode1_select   <= c0_reg[FRC_C0_MODE1];
            ctl.block_access   <= c0_reg[FRC_C0_STOP];
            ctl.abort_cmd      <= abort_reg; // only the command engine halts; reads elsewhere go on
            ctl.clear_suspend  <= clrsusp_reg;
            ctl.lock_disable   <= c1_reg[FRC_C1_LOCKDIS]; // engine bypasses lock, erase then unlocks
            ctl.block_inhibit  <= c1_reg[7:4];
            irq_error  <= aereq_reg && c0_reg[FRC_C0_ERRIE];
            irq_access <= aereq_reg && c0_reg[FRC_C0_AEIE];
            irq_ready  <= rdyreq_reg && c0_reg[FRC_C0_RDYIE];
        end
    end

    // ************
    // assertions
    // ************
    property p_seqrst_abort;
        @(posedge clk) disable iff (!rst_n) seq_go |=> abort_reg [*2];
    endproperty
    a_seqrst_abort: assert property (p_seqrst_abort) else $error("sequence reset did not abort");
    property p_seq_gate;
        @(posedge clk) disable iff (!rst_n) (c0_wr && !c0_reg[FRC_C0_EN]) |=> !abort_reg || $past(abort_reg);
    endproperty
    a_seq_gate: assert property (p_seq_gate) else $error("sequence reset acted while disabled");
    property p_ready_flag;
        @(posedge clk) disable iff (!rst_n) $fell(busy_eff) && c0_reg[FRC_C0_RDYIE] |=> rdyreq_reg;
    endproperty
    a_ready_flag: assert property (p_ready_flag) else $error("ready request not set");
    property p_inh_clear;
        @(posedge clk) disable iff (!rst_n) !c0_reg[FRC_C0_EN] && !c1_wr |=> c1_reg[7:4] == 4'h0;
    endproperty
    a_inh_clear: assert property (p_inh_clear) else $error("inhibit bits kept");
    property p_stop_gate;
        @(posedge clk) disable iff (!rst_n) c0_reg[FRC_C0_STOP] |-> c0_reg[FRC_C0_EN];
    endproperty
    a_stop_gate: assert property (p_stop_gate) else $error("stop without rewrite enable");
    property p_block;
        @(posedge clk) disable iff (!rst_n) c0_reg[FRC_C0_STOP] |=> ctl.block_access;
    endproperty
    a_block: assert property (p_block) else $error("access not blocked");
    property p_lockdis;
        @(posedge clk) disable iff (!rst_n) (eng.prog_done || eng.erase_done) && !c1_wr |=> !c1_reg[FRC_C1_LOCKDIS];
    endproperty
    a_lockdis: assert property (p_lockdis) else $error("lock disable not cleared");
    property p_irq_rdy;
        @(posedge clk) disable iff (!rst_n) rdyreq_reg && c0_reg[FRC_C0_RDYIE] |=> irq_ready;
    endproperty
    a_irq_rdy: assert property (p_irq_rdy) else $error("ready irq missing");

    // a fresh request is answered in the next cycle
    property p_wait_ans;
        @(posedge clk) disable iff (!rst_n) (avs_read || avs_write) && !ack_reg |=> !avs_waitrequest;
    endproperty
    a_wait_ans: assert property (p_wait_ans) else $error("request not answered");

    // the answer stands for one cycle only
    property p_wait_drop;
        @(posedge clk) disable iff (!rst_n) ack_reg |=> avs_waitrequest;
    endproperty
    a_wait_drop: assert property (p_wait_drop) else $error("waitrequest stayed low");

    // status shows ready as sampled at the first edge of the read, one edge before it is accepted
    property p_stat_ready;
        @(posedge clk) disable iff (!rst_n) rd_hit && avs_address == FRC_STATUS_ADDR |=> avs_readdata[FRC_ST_READY] == !$past(busy_eff);
    endproperty
    a_stat_ready: assert property (p_stat_ready) else $error("status ready bit wrong");

    // status shows the suspend level
    property p_stat_susp;
        @(posedge clk) disable iff (!rst_n) rd_hit && avs_address == FRC_STATUS_ADDR |=> avs_readdata[FRC_ST_SUSP] == $past(eng.suspended);
    endproperty
    a_stat_susp: assert property (p_stat_susp) else $error("status suspend bit wrong");

    // erase and blank check failures share one flag
    property p_stat_erserr;
        @(posedge clk) disable iff (!rst_n) rd_hit && avs_address == FRC_STATUS_ADDR
            |=> avs_readdata[FRC_ST_ERSERR] == ($past(eng.erase_err) || $past(eng.blank_err));
    endproperty
    a_stat_erserr: assert property (p_stat_erserr) else $error("status erase error bit wrong");

    // a forced stop reads as busy
    property p_stat_abort;
        @(posedge clk) disable iff (!rst_n) rd_hit && avs_address == FRC_STATUS_ADDR && abort_reg |=> !avs_readdata[FRC_ST_READY];
    endproperty
    a_stat_abort: assert property (p_stat_abort) else $error("busy not shown during forced stop");

    // sequence reset always reads zero
    property p_c0_rd_seq;
        @(posedge clk) disable iff (!rst_n) rd_hit && avs_address == FRC_CTRL0_ADDR |=> !avs_readdata[FRC_C0_SEQRST];
    endproperty
    a_c0_rd_seq: assert property (p_c0_rd_seq) else $error("sequence reset read as one");

    // unused low bits of control one read zero
    property p_c1_rd_low;
        @(posedge clk) disable iff (!rst_n) rd_hit && avs_address == FRC_CTRL1_ADDR |=> avs_readdata[2:0] == 3'b000;
    endproperty
    a_c1_rd_low: assert property (p_c1_rd_low) else $error("control one low bits not zero");

    // the three interrupt enables take the written value
    property p_c0_write;
        @(posedge clk) disable iff (!rst_n) c0_wr |=> (c0_reg >> FRC_C0_ERRIE) == ($past(avs_writedata) >> FRC_C0_ERRIE);
    endproperty
    a_c0_write: assert property (p_c0_write) else $error("irq enables not written");

    // block inhibits take the written value while rewriting is enabled
    property p_c1_write;
        @(posedge clk) disable iff (!rst_n) c1_wr && c0_reg[FRC_C0_EN]
            |=> (c1_reg >> FRC_C1_INH_LO) == ($past(avs_writedata) >> FRC_C1_INH_LO);
    endproperty
    a_c1_write: assert property (p_c1_write) else $error("inhibit bits not written");

    // flash stop drops lock disable
    property p_lock_stop;
        @(posedge clk) disable iff (!rst_n) c0_reg[FRC_C0_STOP] |=> !c1_reg[FRC_C1_LOCKDIS];
    endproperty
    a_lock_stop: assert property (p_lock_stop) else $error("lock disable kept over stop");

    // an accepted sequence reset drops lock disable
    property p_lock_seq;
        @(posedge clk) disable iff (!rst_n) seq_go |=> !c1_reg[FRC_C1_LOCKDIS];
    endproperty
    a_lock_seq: assert property (p_lock_seq) else $error("lock disable kept over sequence reset");

    // rewrite disabled keeps lock disable low
    property p_lock_off;
        @(posedge clk) disable iff (!rst_n) !c0_reg[FRC_C0_EN] |=> !c1_reg[FRC_C1_LOCKDIS];
    endproperty
    a_lock_off: assert property (p_lock_off) else $error("lock disable kept while disabled");

    // entry to suspend drops lock disable
    property p_lock_susp;
        @(posedge clk) disable iff (!rst_n) $rose(eng.suspended) |=> !c1_reg[FRC_C1_LOCKDIS];
    endproperty
    a_lock_susp: assert property (p_lock_susp) else $error("lock disable kept over suspend");

    // a command sequence error drops lock disable
    property p_lock_err;
        @(posedge clk) disable iff (!rst_n) eng.seq_err |=> !c1_reg[FRC_C1_LOCKDIS];
    endproperty
    a_lock_err: assert property (p_lock_err) else $error("lock disable kept over sequence error");

    // the forced stop ends when its count runs out
    property p_abort_end;
        @(posedge clk) disable iff (!rst_n) abort_reg && lat_reg == 8'h01 && !seq_go |=> !abort_reg;
    endproperty
    a_abort_end: assert property (p_abort_end) else $error("forced stop did not end");

    // a reset during suspend also clears the suspended state
    property p_clrsusp;
        @(posedge clk) disable iff (!rst_n) seq_go && eng.suspended |=> clrsusp_reg;
    endproperty
    a_clrsusp: assert property (p_clrsusp) else $error("suspend not cleared");

    // stopping or starting the flash shows busy
    property p_stop_busy;
        @(posedge clk) disable iff (!rst_n) c0_wr && avs_writedata[FRC_C0_STOP] != c0_reg[FRC_C0_STOP] |=> busy_eff;
    endproperty
    a_stop_busy: assert property (p_stop_busy) else $error("stop change not busy");

    // access to the block being rewritten sets the request
    property p_ae_set;
        @(posedge clk) disable iff (!rst_n) eng.busy_access && c0_reg[FRC_C0_AEIE] |=> aereq_reg;
    endproperty
    a_ae_set: assert property (p_ae_set) else $error("access error request not set");

    // command errors set the request while enabled
    property p_err_set;
        @(posedge clk) disable iff (!rst_n) err_any && c0_reg[FRC_C0_ERRIE] |=> aereq_reg;
    endproperty
    a_err_set: assert property (p_err_set) else $error("error request not set");

    // only a status write clears the ready request
    property p_rdy_hold;
        @(posedge clk) disable iff (!rst_n) rdyreq_reg && !(wr_hit && avs_address == FRC_STATUS_ADDR) |=> rdyreq_reg;
    endproperty
    a_rdy_hold: assert property (p_rdy_hold) else $error("ready request lost");

    // no ready request is set while its enable is off
    property p_rdy_none;
        @(posedge clk) disable iff (!rst_n) !rdyreq_reg && !c0_reg[FRC_C0_RDYIE] |=> !rdyreq_reg;
    endproperty
    a_rdy_none: assert property (p_rdy_none) else $error("ready request set while disabled");

    // error interrupt follows its request and enable
    property p_irq_err;
        @(posedge clk) disable iff (!rst_n) aereq_reg && c0_reg[FRC_C0_ERRIE] |=> irq_error;
    endproperty
    a_irq_err: assert property (p_irq_err) else $error("error irq missing");
endmodule : frc_ctrl

// *** sim/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
    import frc_pkg::*;
    // ****************************
    // signals and device under test
    // ****************************
    logic        clk;
    logic        rst_n;
    logic [8:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [7:0]  avs_writedata;
    logic [7:0]  avs_readdata;
    logic        avs_waitrequest;
    frc_engine_t eng;
    frc_ctrl_t   ctl;
    logic        irq_error;
    logic        irq_access;
    logic        irq_ready;
    logic        abort_seen;
    int          bad_count;
    int          comparisons;
    frc_ctrl DUT (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .eng(eng), .ctl(ctl), .irq_error(irq_error),
        .irq_access(irq_access), .irq_ready(irq_ready));
    // ****************************
    // bus and compare helpers
    // ****************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // request held until waitrequest is seen low at a rising edge
    task automatic xfer(input logic [8:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
        avs_address   <= a;
        avs_write     <= w;
        avs_read      <= !w;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : xfer
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(a, 1'b1, d, q);
    endtask : wr
    task automatic rd_chk(input logic [8:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] q;
        xfer(a, 1'b0, 8'h00, q);
        chk(q & m, e);
    endtask : rd_chk
    // abort may be a short pulse, so it is caught sticky
    always @(posedge clk) begin
        if (ctl.abort_cmd === 1'b1) abort_seen <= 1'b1;
    end
    // ****************************
    // scenarios
    // ****************************
    task automatic s_reset_and_mode;
        rd_chk(FRC_CTRL0_ADDR, 8'hff, 8'h00);
        rd_chk(FRC_CTRL1_ADDR, 8'hff, 8'h00);
        rd_chk(FRC_STATUS_ADDR, 8'hc0, 8'h80);
        rd_chk(9'h1b3, 8'hff, 8'h00);
        wr(FRC_CTRL0_ADDR, 8'h00);
        wr(FRC_CTRL0_ADDR, 8'h06);
        rd_chk(FRC_CTRL0_ADDR, 8'hff, 8'h06);
        chk({6'h0, ctl.rewrite_enable, ctl.mode1_select}, 8'h03);
    endtask : s_reset_and_mode
    // sequence reset refused while ready, taken while busy and still reads zero
    task automatic s_seq_reset;
        abort_seen = 1'b0;
        wr(FRC_CTRL0_ADDR, 8'h16);
        chk({7'h0, abort_seen}, 8'h00);
        eng.busy      <= 1'b1;
        eng.suspended <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk(FRC_STATUS_ADDR, 8'h80, 8'h00);
        wr(FRC_CTRL0_ADDR, 8'h16);
        rd_chk(FRC_CTRL0_ADDR, 8'hff, 8'h06);
        chk({7'h0, abort_seen}, 8'h01);
        chk({7'h0, ctl.clear_suspend}, 8'h01);
        eng.busy      <= 1'b0;
        eng.suspended <= 1'b0;
        repeat (3) @(posedge clk);
        // the forced stop keeps the flag busy until its latency runs out
        rd_chk(FRC_STATUS_ADDR, 8'h80, 8'h00);
        repeat (FRC_STOP_LAT_CYC) @(posedge clk);
        rd_chk(FRC_STATUS_ADDR, 8'h81, 8'h80);
    endtask : s_seq_reset
    task automatic s_irqs;
        wr(FRC_CTRL0_ADDR, 8'h82);
        eng.busy <= 1'b1;
        repeat (3) @(posedge clk);
        eng.busy <= 1'b0;
        repeat (3) @(posedge clk);
        chk({7'h0, irq_ready}, 8'h01);
        rd_chk(FRC_STATUS_ADDR, 8'h01, 8'h01);
        wr(FRC_STATUS_ADDR, 8'h00);
        chk({7'h0, irq_ready}, 8'h00);
        wr(FRC_CTRL0_ADDR, 8'h22);
        eng.erase_err <= 1'b1;
        repeat (3) @(posedge clk);
        chk({7'h0, irq_error}, 8'h01);
        rd_chk(FRC_STATUS_ADDR, 8'h22, 8'h22);
        eng.erase_err <= 1'b0;
        wr(FRC_STATUS_ADDR, 8'h00);
        rd_chk(FRC_STATUS_ADDR, 8'h22, 8'h00);
        wr(FRC_CTRL0_ADDR, 8'h42);
        eng.busy_access <= 1'b1;
        @(posedge clk);
        eng.busy_access <= 1'b0;
        repeat (3) @(posedge clk);
        chk({7'h0, irq_access}, 8'h01);
        wr(FRC_STATUS_ADDR, 8'h00);
        chk({5'h0, irq_access, irq_error, irq_ready}, 8'h00);
        eng.suspended <= 1'b1;
        rd_chk(FRC_STATUS_ADDR, 8'h40, 8'h40);
        eng.suspended <= 1'b0;
    endtask : s_irqs
    // lock disable auto-clear, inhibit bits, stop gating
    task automatic s_ctrl_one;
        wr(FRC_CTRL1_ADDR, 8'h00);
        wr(FRC_CTRL1_ADDR, 8'h08);
        chk({7'h0, ctl.lock_disable}, 8'h01);
        eng.prog_done <= 1'b1;
        @(posedge clk);
        eng.prog_done <= 1'b0;
        repeat (2) @(posedge clk);
        chk({7'h0, ctl.lock_disable}, 8'h00);
        wr(FRC_CTRL1_ADDR, 8'hf7);
        rd_chk(FRC_CTRL1_ADDR, 8'hf7, 8'hf0);
        chk({4'h0, ctl.block_inhibit}, 8'h0f);
        wr(FRC_CTRL1_ADDR, 8'hf0);
        wr(FRC_CTRL1_ADDR, 8'h00);
        chk({4'h0, ctl.block_inhibit}, 8'h00);
        wr(FRC_CTRL1_ADDR, 8'hf0);
        wr(FRC_CTRL0_ADDR, 8'h0a);
        chk({7'h0, ctl.block_access}, 8'h01);
        wr(FRC_CTRL0_ADDR, 8'h00);
        rd_chk(FRC_CTRL1_ADDR, 8'hff, 8'h00);
        wr(FRC_CTRL0_ADDR, 8'h08);
        chk({7'h0, ctl.block_access}, 8'h00);
    endtask : s_ctrl_one
    // ****************************
    // verdict, clock, run
    // ****************************
    task automatic print_verdict;
        $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // far above the few hundred cycles the scenarios need
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        print_verdict();
    end
    initial begin
        rst_n = 1'b0;
        avs_address = 9'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 8'h00;
        eng = '0;
        abort_seen = 1'b0;
        bad_count = 0;
        comparisons = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        s_reset_and_mode();
        s_seq_reset();
        s_irqs();
        s_ctrl_one();
        print_verdict();
    end
endmodule : tb_top
